// file: reset_pin_and_cause_control.v
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
`include "reset_cause_defines.vh"
module reset_pin_and_cause_control #(
	parameter WDOG_WIDTH   = 16,
	parameter WDOG_TIMEOUT = 16'd50000
) (
	// clock and power-on reset
	input  wire        clk_i,
	input  wire        resetn_i,
	// apb slave
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [11:0] paddr_i,
	input  wire [31:0] pwdata_i,
	output reg  [31:0] prdata_o,
	output reg         pready_o,
	output reg         pslverr_o,
	// internal reset sources
	input  wire        low_voltage_i,
	input  wire        illegal_opcode_i,
	input  wire        illegal_address_i,
	// shared reset pin
	input  wire        reset_pin_i,
	output reg         reset_pin_o,
	output reg         reset_pin_oe_o,
	output reg         reset_pin_pullup_o,
	output reg         reset_pin_function_o,
	// debug mode select pin
	input  wire        debug_mode_select_pin_i,
	output reg         debug_pin_pullup_o,
	output reg         debug_pin_function_o,
	output reg         background_mode_o,
	// system reset and interrupt
	output reg         system_reset_o,
	output reg         irq_o
);

	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam ST_RUN   = 1'b0;
	localparam ST_RESET = 1'b1;

	reg                  state;
	reg  [6:0]           pulse_cnt;
	reg                  pulse_drives_pin;
	reg                  need_mode_sample;
	reg  [7:0]           reset_cause_status;
	reg                  reset_pin_enable;
	reg                  debug_pin_enable;
	reg                  watchdog_enable;
	reg  [WDOG_WIDTH-1:0] wdog_cnt;
	reg                  wdog_armed;
	reg  [`IRQ_WIDTH-1:0] irq_status;
	reg  [`IRQ_WIDTH-1:0] irq_mask;
	reg  [1:0]           rst_pin_sync;
	reg  [1:0]           dbg_pin_sync;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_pin_sync <= 2'b11;
			dbg_pin_sync <= 2'b11;
		end else begin
			rst_pin_sync <= {rst_pin_sync[0], reset_pin_i};
			dbg_pin_sync <= {dbg_pin_sync[0], debug_mode_select_pin_i};
		end
	end

	wire rst_pin_low = ~rst_pin_sync[1];
	wire dbg_pin_low = ~dbg_pin_sync[1];

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	wire acc    = psel_i & penable_i & pready_o;
	wire wr_acc = acc & pwrite_i;
	wire rd_acc = acc & ~pwrite_i;
	wire sel_opt   = (paddr_i == `OFF_SYSTEM_OPTIONS_ONE);
	wire sel_cause = (paddr_i == `OFF_RESET_CAUSE_STATUS);
	wire sel_force = (paddr_i == `OFF_DEBUG_FORCE_RESET);
	wire sel_ists  = (paddr_i == `OFF_IRQ_STATUS);
	wire sel_imask = (paddr_i == `OFF_IRQ_MASK);
	wire sel_any   = sel_opt | sel_cause | sel_force | sel_ists | sel_imask;
	wire [7:0] wbyte = pwdata_i[7:0];

	// ----------------------------------------
	// watchdog and reset sources
	// ----------------------------------------
	wire in_run   = (state == ST_RUN);
	wire cause_wr = wr_acc & sel_cause & in_run;
	wire wr_first = (wbyte == `WDOG_SERVICE_FIRST);
	wire wr_second = (wbyte == `WDOG_SERVICE_SECOND);
	// other values are a deliberate trip, so runaway code cannot service
	wire wdog_bad_write = cause_wr & watchdog_enable
		& ~wr_first & ~wr_second;
	wire wdog_service   = cause_wr & wr_second & wdog_armed;
	wire wdog_timeout = in_run & watchdog_enable
		& (wdog_cnt == WDOG_TIMEOUT);
	wire wdog_src = wdog_timeout | wdog_bad_write;
	wire pin_src  = in_run & reset_pin_enable & rst_pin_low;
	wire force_src = in_run & wr_acc & sel_force
		& pwdata_i[`DEBUG_FORCE_RESET_BIT];
	wire lvd_src  = in_run & low_voltage_i;
	wire illegal_opcode_flag_src = in_run & illegal_opcode_i;
	wire illegal_address_flag_src = in_run & illegal_address_i;
	wire reset_entry = pin_src | wdog_src | force_src | lvd_src
		| illegal_opcode_flag_src | illegal_address_flag_src;
	wire wdog_half = in_run & watchdog_enable
		& (wdog_cnt == (WDOG_TIMEOUT >> 1));

	// ----------------------------------------
	// cause decode at reset entry
	// ----------------------------------------
	reg [7:0] next_cause;
	always @* begin
		next_cause = `CAUSE_NONE;
		if (lvd_src) begin
			// low voltage keeps the power-on flag as it was
			next_cause[`CAUSE_POR]         = reset_cause_status[`CAUSE_POR];
			next_cause[`CAUSE_LOW_VOLTAGE] = 1'b1;
		end else if (force_src) begin
			next_cause = `CAUSE_NONE;
		end else begin
			next_cause[`CAUSE_PIN]             = pin_src;
			next_cause[`CAUSE_WATCHDOG]        = wdog_src;
			next_cause[`CAUSE_ILLEGAL_OPCODE]  = illegal_opcode_flag_src;
			next_cause[`CAUSE_ILLEGAL_ADDRESS] = illegal_address_flag_src;
		end
	end

	// ----------------------------------------
	// reset sequencer
	// ----------------------------------------
	// pulse_cnt runs past the pulse for a few cycles so the pin
	// synchroniser cannot mistake our own low for an external reset
	wire seq_done = (pulse_cnt == `RST_PULSE_CYCLES + `PIN_SETTLE_CYCLES - 7'd1);
	wire pulse_last = (pulse_cnt == `RST_PULSE_CYCLES - 7'd1);

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state              <= ST_RESET;
			pulse_cnt          <= 7'd0;
			pulse_drives_pin   <= 1'b0;
			need_mode_sample   <= 1'b1;
			system_reset_o     <= 1'b1;
		end else begin
			case (state)
			ST_RUN: begin
				if (reset_entry) begin
					state              <= ST_RESET;
					pulse_cnt          <= 7'd0;
					// only non-power-on resets reach here
					pulse_drives_pin   <= reset_pin_enable;
					need_mode_sample   <= force_src;
					system_reset_o     <= 1'b1;
				end
			end
			ST_RESET: begin
				pulse_cnt <= pulse_cnt + 7'd1;
				if (pulse_last) begin
					pulse_drives_pin <= 1'b0;
				end
				if (seq_done) begin
					state            <= ST_RUN;
					system_reset_o   <= 1'b0;
					need_mode_sample <= 1'b0;
				end
			end
			default: begin
				state <= ST_RESET;
			end
			endcase
		end
	end

	// ----------------------------------------
	// reset cause register
	// ----------------------------------------
	// loaded only at reset entry, so no bus write can reach it
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reset_cause_status <= `CAUSE_POR_VALUE;
		end else if (in_run & reset_entry) begin
			reset_cause_status <= next_cause;
		end
	end

	// ----------------------------------------
	// mode select
	// ----------------------------------------
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			background_mode_o <= 1'b0;
		end else if ((state == ST_RESET) & seq_done) begin
			if (need_mode_sample) begin
				// pin held low by the host selects background
				background_mode_o <= dbg_pin_low;
			end else begin
				background_mode_o <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// pin drivers
	// ----------------------------------------
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reset_pin_o          <= 1'b0;
			reset_pin_oe_o       <= 1'b0;
			reset_pin_pullup_o   <= 1'b0;
			reset_pin_function_o <= 1'b0;
			debug_pin_pullup_o   <= 1'b1;
			debug_pin_function_o <= 1'b1;
		end else begin
			// open drain: only ever drives low
			reset_pin_o          <= 1'b0;
			reset_pin_oe_o       <= pulse_drives_pin;
			reset_pin_pullup_o   <= reset_pin_enable;
			reset_pin_function_o <= reset_pin_enable;
			debug_pin_pullup_o   <= debug_pin_enable;
			debug_pin_function_o <= debug_pin_enable;
		end
	end

	// ----------------------------------------
	// software control bits
	// ----------------------------------------
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reset_pin_enable <= 1'b0;
			debug_pin_enable <= 1'b1;
			watchdog_enable  <= `WATCHDOG_ENABLE_RESET;
		end else if (state == ST_RESET) begin
			debug_pin_enable <= 1'b1;
			watchdog_enable  <= `WATCHDOG_ENABLE_RESET;
		end else if (wr_acc & sel_opt) begin
			// set only: a later write of zero cannot release the pin
			if (pwdata_i[`SOPT_RESET_PIN_ENABLE]) begin
				reset_pin_enable <= 1'b1;
			end
			debug_pin_enable <= pwdata_i[`SOPT_DEBUG_PIN_ENABLE];
			watchdog_enable  <= pwdata_i[`SOPT_WATCHDOG_ENABLE];
		end
	end

	// ----------------------------------------
	// watchdog counter
	// ----------------------------------------
	// held at zero outside run, so it cannot trip during a reset
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wdog_cnt   <= {WDOG_WIDTH{1'b0}};
			wdog_armed <= 1'b0;
		end else if (!in_run || !watchdog_enable || wdog_service) begin
			wdog_cnt   <= {WDOG_WIDTH{1'b0}};
			wdog_armed <= 1'b0;
		end else begin
			wdog_cnt <= wdog_cnt + {{(WDOG_WIDTH-1){1'b0}}, 1'b1};
			if (cause_wr) begin
				wdog_armed <= wr_first;
			end
		end
	end

	// ----------------------------------------
	// interrupt status and mask
	// ----------------------------------------
	wire [`IRQ_WIDTH-1:0] irq_set;
	assign irq_set[`IRQ_RESET_DONE]    = (state == ST_RESET) & seq_done;
	assign irq_set[`IRQ_WDOG_SERVICED] = wdog_service;
	assign irq_set[`IRQ_WDOG_HALFWAY]  = wdog_half;

	genvar gi;
	generate
		for (gi = 0; gi < `IRQ_WIDTH; gi = gi + 1) begin : g_irq
			// a new event in the read cycle survives the clear
			always @(posedge clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					irq_status[gi] <= 1'b0;
				end else if (irq_set[gi]) begin
					irq_status[gi] <= 1'b1;
				end else if (rd_acc & sel_ists) begin
					irq_status[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_mask <= {`IRQ_WIDTH{1'b0}};
			irq_o    <= 1'b0;
		end else begin
			if (wr_acc & sel_imask) begin
				irq_mask <= pwdata_i[`IRQ_WIDTH-1:0];
			end
			irq_o <= |(irq_status & irq_mask);
		end
	end

	// ----------------------------------------
	// apb read data and handshake
	// ----------------------------------------
	reg [31:0] next_rdata;
	always @* begin
		next_rdata = 32'h0000_0000;
		case (1'b1)
		sel_opt: begin
			next_rdata[`SOPT_RESET_PIN_ENABLE] = reset_pin_enable;
			next_rdata[`SOPT_DEBUG_PIN_ENABLE] = debug_pin_enable;
			next_rdata[`SOPT_WATCHDOG_ENABLE]  = watchdog_enable;
		end
		// flags are read-only; bits 2 and 0 stay zero
		sel_cause: next_rdata[7:0] = reset_cause_status;
		sel_ists:  next_rdata[`IRQ_WIDTH-1:0] = irq_status;
		sel_imask: next_rdata[`IRQ_WIDTH-1:0] = irq_mask;
		default:   next_rdata = 32'h0000_0000;
		endcase
	end

	wire ans_cycle = psel_i & penable_i & ~pready_o;

	// one wait state: pready rises in the second access cycle
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pready_o <= 1'b0;
		end else begin
			pready_o <= ans_cycle;
		end
	end

	// unmapped offsets answer with an error and read as zero
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pslverr_o <= 1'b0;
		end else begin
			pslverr_o <= ans_cycle & ~sel_any;
		end
	end

	// data stands only in the answer cycle, zero otherwise
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (ans_cycle & ~pwrite_i) begin
			prdata_o <= next_rdata;
		end else begin
			prdata_o <= 32'h0000_0000;
		end
	end

endmodule

// file: reset_cause_defines.vh
`ifndef RESET_CAUSE_DEFINES_VH
`define RESET_CAUSE_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFF_SYSTEM_OPTIONS_ONE   12'h000
`define OFF_RESET_CAUSE_STATUS   12'h004
`define OFF_DEBUG_FORCE_RESET    12'h008
`define OFF_IRQ_STATUS           12'h00c
`define OFF_IRQ_MASK             12'h010

// ----------------------------------------
// system_options_one fields
// ----------------------------------------
`define SOPT_RESET_PIN_ENABLE    0
`define SOPT_DEBUG_PIN_ENABLE    1
`define SOPT_WATCHDOG_ENABLE     2
`define WATCHDOG_ENABLE_RESET    1'b1

// ----------------------------------------
// reset_cause_status fields and values
// ----------------------------------------
`define CAUSE_POR                7
`define CAUSE_PIN                6
`define CAUSE_WATCHDOG           5
`define CAUSE_ILLEGAL_OPCODE     4
`define CAUSE_ILLEGAL_ADDRESS    3
`define CAUSE_LOW_VOLTAGE        1
`define CAUSE_POR_VALUE          8'h82
`define CAUSE_NONE               8'h00
`define WDOG_SERVICE_FIRST       8'h55
`define WDOG_SERVICE_SECOND      8'haa

// ----------------------------------------
// debug_force_reset_register and irq fields
// ----------------------------------------
`define DEBUG_FORCE_RESET_BIT    0
`define IRQ_RESET_DONE           0
`define IRQ_WDOG_SERVICED        1
`define IRQ_WDOG_HALFWAY         2
`define IRQ_WIDTH                3

// ----------------------------------------
// timing in bus clock cycles
// ----------------------------------------
`define RST_PULSE_CYCLES         7'd66
`define PIN_SETTLE_CYCLES        7'd3

`endif

// file: reset_ctl_asserts.sv
`timescale 1ns/1ps
// -----------------
// reset pin, debug pin and bus checks
// -----------------
module reset_ctl_asserts (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pready_o,
	input wire logic system_reset_o,
	input wire logic reset_pin_oe_o,
	input wire logic reset_pin_pullup_o,
	input wire logic reset_pin_function_o,
	input wire logic debug_pin_pullup_o,
	input wire logic debug_pin_function_o
);
	logic [6:0] oe_cnt;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// width judged where the drive ends, too long for a repetition
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			oe_cnt <= 7'h00;
		else if (reset_pin_oe_o)
			oe_cnt <= oe_cnt + 7'h01;
		else
			oe_cnt <= 7'h00;
	end
	a_pulse_width: assert property (
		$fell(reset_pin_oe_o) |-> oe_cnt == 7'h42)
		else $error("pin pulse width wrong");
	a_port_no_drive: assert property (
		reset_pin_oe_o |-> reset_pin_function_o)
		else $error("pin driven while port pin");
	a_pin_sticky: assert property (
		!$fell(reset_pin_function_o))
		else $error("reset pin function dropped");
	a_pin_pullup: assert property (
		reset_pin_pullup_o == reset_pin_function_o)
		else $error("reset pin pull-up mismatch");
	a_debug_pullup: assert property (
		debug_pin_pullup_o == debug_pin_function_o)
		else $error("debug pull-up mismatch");
	a_debug_restored: assert property (
		$fell(system_reset_o) |-> debug_pin_function_o)
		else $error("debug pin not enabled after reset");
	a_drive_in_reset: assert property (
		$rose(reset_pin_oe_o) |-> $past(system_reset_o))
		else $error("pin drive outside reset");
	a_settle_release: assert property (
		$fell(reset_pin_oe_o) |->
		system_reset_o ##1 system_reset_o ##1 !system_reset_o)
		else $error("reset release not three after drive");
	a_one_wait: assert property (
		$rose(penable_i) && psel_i |-> !pready_o ##1 pready_o)
		else $error("bus answer not after one wait");
endmodule

bind reset_pin_and_cause_control reset_ctl_asserts u_chk (.clk_i,
	.resetn_i, .psel_i, .penable_i, .pready_o, .system_reset_o,
	.reset_pin_oe_o, .reset_pin_pullup_o, .reset_pin_function_o,
	.debug_pin_pullup_o, .debug_pin_function_o);

// file: reset_party.sv
`timescale 1ns/1ps
// ------------------------------------
// external reset source and debug host
// ------------------------------------
module reset_party (
	input  wire logic clk_i,
	input  wire logic reset_pin_o,
	input  wire logic reset_pin_oe_o,
	output wire logic reset_pin_i,
	output wire logic debug_mode_select_pin_i
);
	logic pull_low = 1'b0;
	logic hold_low = 1'b0;
	// open drain with pull-up: any party pulling low wins
	assign reset_pin_i = ((reset_pin_oe_o && !reset_pin_o) || pull_low) ?
		1'b0 : 1'b1;
	assign debug_mode_select_pin_i = !hold_low;
	task automatic pull_reset(input int n);
		@(posedge clk_i);
		pull_low <= 1'b1;
		repeat (n) @(posedge clk_i);
		pull_low <= 1'b0;
	endtask
	task automatic hold_debug(input logic v);
		@(posedge clk_i);
		hold_low <= v;
	endtask
endmodule

// file: tb.sv
`timescale 1ns/1ps
// ---------
// testbench
// ---------
module tb;
	typedef struct packed {
		logic        w;
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] x;
		logic        e;
	} row_t;
	logic        clk_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic        psel_i = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic [31:0] rd;
	logic        pready_o, pslverr_o, er, irq_o;
	logic        low_voltage_i = 1'b0;
	logic        illegal_opcode_i = 1'b0;
	logic        illegal_address_i = 1'b0;
	logic        reset_pin_i, reset_pin_o, reset_pin_oe_o;
	logic        reset_pin_pullup_o, reset_pin_function_o;
	logic        debug_mode_select_pin_i, debug_pin_pullup_o;
	logic        debug_pin_function_o, background_mode_o, system_reset_o;
	int          miscompares = 0;
	int          n_tests = 0;
	int          k, n;
	row_t        rows [12] = '{
		'{1'b0, 12'h004, 32'h0, 32'h82, 1'b0},
		'{1'b0, 12'h000, 32'h0, 32'h6, 1'b0},
		'{1'b1, 12'h004, 32'h55, 32'h0, 1'b0},
		'{1'b1, 12'h004, 32'haa, 32'h0, 1'b0},
		'{1'b0, 12'h004, 32'h0, 32'h82, 1'b0},
		'{1'b0, 12'h008, 32'h0, 32'h0, 1'b0},
		'{1'b0, 12'h014, 32'h0, 32'h0, 1'b1},
		'{1'b1, 12'h010, 32'h2, 32'h0, 1'b0},
		'{1'b0, 12'h010, 32'h0, 32'h2, 1'b0},
		'{1'b1, 12'h000, 32'h1, 32'h0, 1'b0},
		'{1'b1, 12'h000, 32'h0, 32'h0, 1'b0},
		'{1'b0, 12'h000, 32'h0, 32'h1, 1'b0}};

	always #4 clk_i = ~clk_i;

	// short watchdog timeout keeps the run small
	reset_pin_and_cause_control #(.WDOG_TIMEOUT(16'h00c8)) i_dut (.clk_i,
		.resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .low_voltage_i, .illegal_opcode_i,
		.illegal_address_i, .reset_pin_i, .reset_pin_o, .reset_pin_oe_o,
		.reset_pin_pullup_o, .reset_pin_function_o, .debug_mode_select_pin_i,
		.debug_pin_pullup_o, .debug_pin_function_o, .background_mode_o,
		.system_reset_o, .irq_o);
	reset_party i_party (.clk_i, .reset_pin_o, .reset_pin_oe_o, .reset_pin_i,
		.debug_mode_select_pin_i);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("compared %0d, mismatched %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic por_wait;
		k = 0;
		while (system_reset_o !== 1'b0 && k < 200) begin
			@(negedge clk_i);
			k++;
		end
		chk(system_reset_o, 32'h0);
	endtask
	// sampled at the falling edge, where outputs have settled
	task automatic reset_seq(input logic [7:0] cause, input int exp_n);
		k = 0;
		n = 0;
		while (system_reset_o !== 1'b1 && k < 150) begin
			@(negedge clk_i);
			k++;
		end
		while (system_reset_o === 1'b1 && k < 300) begin
			@(negedge clk_i);
			k++;
			if (reset_pin_oe_o === 1'b1)
				n++;
		end
		chk(system_reset_o, 32'h0);
		chk(n, exp_n);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, {24'h0, cause});
	endtask

	initial begin
		#20000;
		miscompares++;
		tally_and_finish;
	end
	initial begin
		repeat (2) @(posedge clk_i);
		resetn_i <= 1'b1;
		por_wait;
		chk(reset_pin_function_o, 1'b0);
		chk(debug_pin_pullup_o, 1'b1);
		chk(background_mode_o, 1'b0);
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w)
				chk(rd, rows[i].x);
			chk(er, rows[i].e);
		end
		@(negedge clk_i);
		chk(irq_o, 1'b1);
		chk(debug_pin_pullup_o, 1'b0);
		chk(reset_pin_function_o, 1'b1);
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd[1], 1'b1);
		repeat (3) @(negedge clk_i);
		chk(irq_o, 1'b0);
		fork
			i_party.pull_reset(4);
		join_none
		reset_seq(8'h40, 66);
		chk(debug_pin_function_o, 1'b1);
		apb(1'b1, 12'h004, 32'h12);
		reset_seq(8'h20, 66);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_i);
			illegal_opcode_i <= (i == 0);
			illegal_address_i <= (i == 1);
			low_voltage_i <= (i == 2);
			@(posedge clk_i);
			illegal_opcode_i <= 1'b0;
			illegal_address_i <= 1'b0;
			low_voltage_i <= 1'b0;
			reset_seq(i == 0 ? 8'h10 : i == 1 ? 8'h08 : 8'h02, 66);
		end
		for (int i = 0; i < 2; i++) begin
			i_party.hold_debug(i == 0);
			apb(1'b1, 12'h008, 32'h1);
			reset_seq(8'h00, 66);
			chk(background_mode_o, i == 0);
			i_party.hold_debug(1'b0);
		end
		i_party.hold_debug(1'b1);
		@(posedge clk_i);
		resetn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		resetn_i <= 1'b1;
		por_wait;
		chk(reset_pin_function_o, 1'b0);
		chk(background_mode_o, 1'b1);
		i_party.hold_debug(1'b0);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h82);
		// unserviced watchdog: half-way event, then a timeout reset
		apb(1'b1, 12'h010, 32'h4);
		repeat (110) @(negedge clk_i);
		chk(irq_o, 1'b1);
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd, 32'h5);
		reset_seq(8'h20, 0);
		tally_and_finish;
	end
endmodule
